// *** logic/ebt_consts.svh ***
`ifndef EBT_CONSTS_SVH
`define EBT_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define EBT_ADDR_CTRL     4'h0
`define EBT_ADDR_OUTSEL   4'h1
`define EBT_ADDR_COUNT    4'h2
`define EBT_ADDR_CMPA     4'h3
`define EBT_ADDR_CMPB     4'h4
`define EBT_ADDR_CMPC     4'h5
`define EBT_ADDR_FLAGS    4'h6
`define EBT_ADDR_MASK     4'h7

////////////////////////////////////////////////////////////////////////////////
// timer_control fields
`define EBT_CKS_MSB       2
`define EBT_CKS_LSB       0
`define EBT_CCLR_MSB      4
`define EBT_CCLR_LSB      3
`define EBT_CAPEN_BIT     5
`define EBT_CTRL_W        6
`define EBT_OUTSEL_W      4

`define EBT_CKS_STOP      3'h0
`define EBT_CKS_DIV8      3'h1
`define EBT_CKS_DIV64     3'h2
`define EBT_CKS_DIV8192   3'h3
`define EBT_CKS_EXT_RISE  3'h4
`define EBT_CKS_EXT_FALL  3'h5
`define EBT_CKS_EXT_BOTH  3'h6

`define EBT_CCLR_NONE     2'h0
`define EBT_CCLR_MATCHA   2'h1
`define EBT_CCLR_MATCHB   2'h2
`define EBT_CCLR_EXTRST   2'h3

////////////////////////////////////////////////////////////////////////////////
// prescaler taps
`define EBT_PRESC_W       13
`define EBT_TAP_DIV8      2
`define EBT_TAP_DIV64     5
`define EBT_TAP_DIV8192   12

////////////////////////////////////////////////////////////////////////////////
// output actions, numeric order equals priority
`define EBT_ACT_KEEP      2'h0
`define EBT_ACT_LOW       2'h1
`define EBT_ACT_HIGH      2'h2
`define EBT_ACT_TOGGLE    2'h3

////////////////////////////////////////////////////////////////////////////////
// flag bits
`define EBT_FLAGS_W       5
`define EBT_FLG_MA        0
`define EBT_FLG_MB        1
`define EBT_FLG_OVF       2
`define EBT_FLG_MC        3
`define EBT_FLG_CAP       4

////////////////////////////////////////////////////////////////////////////////
// reset values and limits
`define EBT_RST_BYTE      8'h00
`define EBT_RST_CMP       8'hff
`define EBT_CNT_MAX       8'hff
`define EBT_RST_OUT       1'b0

////////////////////////////////////////////////////////////////////////////////
// synchronised pin indices
`define EBT_IN_W          3
`define EBT_IN_ECLK       0
`define EBT_IN_ERST       1
`define EBT_IN_CAP        2

`endif

// *** logic/ebt_pkg.sv ***
package ebt_pkg;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ebt_bus_req_t;

	typedef struct packed {
		logic capture;
		logic ext_reset;
		logic ext_clk;
	} ebt_pins_t;

endpackage : ebt_pkg

// *** logic/ebt_sync.sv ***
`timescale 1ns/1ps
`include "ebt_consts.svh"

module ebt_sync (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	// raw pins
	input  wire logic [`EBT_IN_W-1:0] pin_i,
	// filtered level and edges
	output logic      [`EBT_IN_W-1:0] level_o,
	output logic      [`EBT_IN_W-1:0] rise_o,
	output logic      [`EBT_IN_W-1:0] fall_o
);

	logic [`EBT_IN_W-1:0] s1_reg;
	logic [`EBT_IN_W-1:0] s2_reg;
	logic [`EBT_IN_W-1:0] s3_reg;
	logic [`EBT_IN_W-1:0] level_reg;
	logic [`EBT_IN_W-1:0] level_next;

	genvar g;
	generate
		for (g = 0; g < `EBT_IN_W; g = g + 1) begin : g_bit
			// a change counts only once stages two and three agree
			assign level_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : level_reg[g];
			assign rise_o[g]     = level_next[g] & ~level_reg[g];
			assign fall_o[g]     = ~level_next[g] & level_reg[g];
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			level_reg <= '0;
		end else begin
			s1_reg    <= pin_i;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level_o = level_reg;

endmodule : ebt_sync

// *** logic/ebt_timer.sv ***
`timescale 1ns/1ps
`include "ebt_consts.svh"

module ebt_timer
	import ebt_pkg::*;
(
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// register port
	input  wire ebt_bus_req_t bus_i,
	output logic        [7:0] rdata_o,
	// pins
	input  wire ebt_pins_t    pins_i,
	output logic              timer_out_o,
	// interrupt
	output logic              irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	// higher code wins when both matches ask for an action
	function automatic logic [1:0] pick_action(input logic [1:0] a, input logic [1:0] b);
		pick_action = (a > b) ? a : b;
	endfunction : pick_action

	function automatic logic hit(input ebt_bus_req_t req, input logic [3:0] addr);
		hit = (req.addr == addr);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [`EBT_CTRL_W-1:0]   ctrl_reg;
	logic [`EBT_OUTSEL_W-1:0] outsel_reg;
	logic [7:0]               up_counter_reg;
	logic [7:0]               up_counter_next;
	logic [7:0]               compare_value_a_reg;
	logic [7:0]               compare_value_b_reg;
	logic [7:0]               capture_compare_value_reg;
	logic [`EBT_FLAGS_W-1:0]  flags_reg;
	logic [`EBT_FLAGS_W-1:0]  flags_next;
	logic [`EBT_FLAGS_W-1:0]  mask_reg;
	logic [`EBT_PRESC_W-1:0]  presc_reg;
	logic                     src_lvl_reg;
	logic                     timer_out_reg;
	logic                     timer_out_next;
	logic [7:0]               rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [`EBT_IN_W-1:0] in_lvl;
	logic [`EBT_IN_W-1:0] in_rise;
	logic [`EBT_IN_W-1:0] in_fall;

	ebt_sync u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pin_i   ({pins_i.capture, pins_i.ext_reset, pins_i.ext_clk}),
		.level_o (in_lvl),
		.rise_o  (in_rise),
		.fall_o  (in_fall)
	);

	////////////////////////////////////////////////////////////////////////////
	// address decode

	wire wr_ctrl   = bus_i.wr && hit(bus_i, `EBT_ADDR_CTRL);
	wire wr_outsel = bus_i.wr && hit(bus_i, `EBT_ADDR_OUTSEL);
	wire wr_count  = bus_i.wr && hit(bus_i, `EBT_ADDR_COUNT);
	wire wr_cmpa   = bus_i.wr && hit(bus_i, `EBT_ADDR_CMPA);
	wire wr_cmpb   = bus_i.wr && hit(bus_i, `EBT_ADDR_CMPB);
	wire wr_cmpc   = bus_i.wr && hit(bus_i, `EBT_ADDR_CMPC);
	wire wr_mask   = bus_i.wr && hit(bus_i, `EBT_ADDR_MASK);
	wire rd_flags  = bus_i.rd && hit(bus_i, `EBT_ADDR_FLAGS);

	wire [2:0] cks    = ctrl_reg[`EBT_CKS_MSB:`EBT_CKS_LSB];
	wire [1:0] cclr   = ctrl_reg[`EBT_CCLR_MSB:`EBT_CCLR_LSB];
	wire       cap_en = ctrl_reg[`EBT_CAPEN_BIT];

	////////////////////////////////////////////////////////////////////////////
	// count source
	// internal and single-edge external sources feed one level and one falling-edge
	// detector, while both-edge mode counts synchroniser edges; any switch into a mode
	// other than both-edge that drops the level counts once; that is the
	// documented behaviour, not a bug to filter away

	logic src_lvl;

	always_comb begin
		case (cks)
			`EBT_CKS_STOP:     src_lvl = 1'b0;
			`EBT_CKS_DIV8:     src_lvl = presc_reg[`EBT_TAP_DIV8];
			`EBT_CKS_DIV64:    src_lvl = presc_reg[`EBT_TAP_DIV64];
			`EBT_CKS_DIV8192:  src_lvl = presc_reg[`EBT_TAP_DIV8192];
			`EBT_CKS_EXT_RISE: src_lvl = ~in_lvl[`EBT_IN_ECLK];
			`EBT_CKS_EXT_FALL: src_lvl = in_lvl[`EBT_IN_ECLK];
			`EBT_CKS_EXT_BOTH: src_lvl = in_lvl[`EBT_IN_ECLK];
			default:           src_lvl = 1'b0;
		endcase
	end

	wire ext_both  = (cks == `EBT_CKS_EXT_BOTH);
	wire ext_edge  = in_rise[`EBT_IN_ECLK] | in_fall[`EBT_IN_ECLK];
	wire fall_det  = src_lvl_reg & ~src_lvl;
	wire cnt_pulse = ext_both ? ext_edge : fall_det;

	////////////////////////////////////////////////////////////////////////////
	// compare-match

	wire capture_evt = cap_en & in_rise[`EBT_IN_CAP];

	// match fires at the count clock while counter still equals compare
	wire eq_a    = (up_counter_reg == compare_value_a_reg);
	wire eq_b    = (up_counter_reg == compare_value_b_reg);
	wire eq_c    = (up_counter_reg == capture_compare_value_reg);
	wire match_a = cnt_pulse & eq_a & ~wr_cmpa;
	wire match_b = cnt_pulse & eq_b & ~wr_cmpb;
	wire match_c = cnt_pulse & eq_c & ~wr_cmpc & ~capture_evt;

	////////////////////////////////////////////////////////////////////////////
	// counter

	wire clr_a   = (cclr == `EBT_CCLR_MATCHA) & match_a;
	wire clr_b   = (cclr == `EBT_CCLR_MATCHB) & match_b;
	wire clr_ext = (cclr == `EBT_CCLR_EXTRST) & in_rise[`EBT_IN_ERST];
	wire clr_evt = clr_a | clr_b | clr_ext;

	always_comb begin
		if (clr_evt) begin
			up_counter_next = `EBT_RST_BYTE;
		end else if (wr_count) begin
			up_counter_next = bus_i.wdata;
		end else if (cnt_pulse) begin
			up_counter_next = up_counter_reg + 8'h01;
		end else begin
			up_counter_next = up_counter_reg;
		end
	end

	wire ovf_evt = cnt_pulse & ~clr_evt & ~wr_count & (up_counter_reg == `EBT_CNT_MAX);

	////////////////////////////////////////////////////////////////////////////
	// timer output
	// match a and b share one pin; with clear on a and set/reset
	// actions the pin runs a pulse train with no software help

	wire [1:0] act_a = match_a ? outsel_reg[1:0] : `EBT_ACT_KEEP;
	wire [1:0] act_b = match_b ? outsel_reg[3:2] : `EBT_ACT_KEEP;
	wire [1:0] act   = pick_action(act_a, act_b);

	always_comb begin
		case (act)
			`EBT_ACT_KEEP:   timer_out_next = timer_out_reg;
			`EBT_ACT_LOW:    timer_out_next = 1'b0;
			`EBT_ACT_HIGH:   timer_out_next = 1'b1;
			`EBT_ACT_TOGGLE: timer_out_next = ~timer_out_reg;
			default:         timer_out_next = timer_out_reg;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// flags and interrupt
	// set beats the read-clear so an event in the read cycle survives

	wire [`EBT_FLAGS_W-1:0] flag_set = {capture_evt, match_c, ovf_evt, match_b, match_a};

	assign flags_next = (rd_flags ? {`EBT_FLAGS_W{1'b0}} : flags_reg) | flag_set;

	////////////////////////////////////////////////////////////////////////////
	// read mux

	logic [7:0] rd_mux;

	always_comb begin
		case (bus_i.addr)
			`EBT_ADDR_CTRL:   rd_mux = {2'h0, ctrl_reg};
			`EBT_ADDR_OUTSEL: rd_mux = {4'h0, outsel_reg};
			`EBT_ADDR_COUNT:  rd_mux = up_counter_reg;
			`EBT_ADDR_CMPA:   rd_mux = compare_value_a_reg;
			`EBT_ADDR_CMPB:   rd_mux = compare_value_b_reg;
			`EBT_ADDR_CMPC:   rd_mux = capture_compare_value_reg;
			`EBT_ADDR_FLAGS:  rd_mux = {3'h0, flags_reg};
			`EBT_ADDR_MASK:   rd_mux = {3'h0, mask_reg};
			default:          rd_mux = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			presc_reg   <= '0;
			src_lvl_reg <= 1'b0;
		end else begin
			presc_reg   <= presc_reg + 13'h0001;
			src_lvl_reg <= src_lvl;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg   <= '0;
			outsel_reg <= '0;
			mask_reg   <= '0;
		end else begin
			if (wr_ctrl)   ctrl_reg   <= bus_i.wdata[`EBT_CTRL_W-1:0];
			if (wr_outsel) outsel_reg <= bus_i.wdata[`EBT_OUTSEL_W-1:0];
			if (wr_mask)   mask_reg   <= bus_i.wdata[`EBT_FLAGS_W-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			compare_value_a_reg <= `EBT_RST_CMP;
			compare_value_b_reg <= `EBT_RST_CMP;
		end else begin
			if (wr_cmpa) compare_value_a_reg <= bus_i.wdata;
			if (wr_cmpb) compare_value_b_reg <= bus_i.wdata;
		end
	end

	// capture outranks a bus write landing in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			capture_compare_value_reg <= `EBT_RST_CMP;
		end else if (capture_evt) begin
			capture_compare_value_reg <= up_counter_reg;
		end else if (wr_cmpc) begin
			capture_compare_value_reg <= bus_i.wdata;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_counter_reg <= `EBT_RST_BYTE;
			timer_out_reg  <= `EBT_RST_OUT;
			flags_reg      <= '0;
			rdata_reg      <= `EBT_RST_BYTE;
		end else begin
			up_counter_reg <= up_counter_next;
			timer_out_reg  <= timer_out_next;
			flags_reg      <= flags_next;
			rdata_reg      <= bus_i.rd ? rd_mux : `EBT_RST_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign rdata_o     = rdata_reg;
	assign timer_out_o = timer_out_reg;
	assign irq_o       = |(flags_reg & mask_reg);

endmodule : ebt_timer

// *** testbench/ebt_timer_checker.sv ***
`timescale 1ns/1ps
`include "ebt_consts.svh"

module ebt_timer_checker
	import ebt_pkg::*;
(
	// clock and reset
	input wire logic         clk_i,
	input wire logic         rst_n_i,
	// register port
	input wire ebt_bus_req_t bus_i,
	input wire logic   [7:0] rdata_o,
	// pins
	input wire ebt_pins_t    pins_i,
	input wire logic         timer_out_o,
	input wire logic         irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// shadows built from bus writes only, never from the design's state
	logic [7:0] ctrl_reg;
	logic [7:0] outsel_reg;
	logic [7:0] mask_reg;
	logic [1:0] stop_reg;
	wire        is_wr  = bus_i.wr;
	wire        is_rd  = bus_i.rd;
	wire  [3:0] addr   = bus_i.addr;
	wire        rd_ctl = is_rd && addr == `EBT_ADDR_CTRL;
	wire        rd_os  = is_rd && addr == `EBT_ADDR_OUTSEL;
	wire        rd_msk = is_rd && addr == `EBT_ADDR_MASK;
	wire        wr_cmp = is_wr && (addr == `EBT_ADDR_CMPA || addr == `EBT_ADDR_CMPB);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg   <= 8'h00;
			outsel_reg <= 8'h00;
			mask_reg   <= 8'h00;
			stop_reg   <= 2'h0;
		end else begin
			if (is_wr && addr == `EBT_ADDR_CTRL) ctrl_reg <= bus_i.wdata;
			if (is_wr && addr == `EBT_ADDR_OUTSEL) outsel_reg <= bus_i.wdata;
			if (is_wr && addr == `EBT_ADDR_MASK) mask_reg <= bus_i.wdata;
			// saturating: a stop write may still count once, so wait it out
			if (ctrl_reg[2:0] != `EBT_CKS_STOP) stop_reg <= 2'h0;
			else if (stop_reg != 2'h3) stop_reg <= stop_reg + 2'h1;
		end
	end

	////////////////////////////////////////
	property p_rd_idle; !$past(is_rd) |-> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unmapped; $past(is_rd && addr[3]) |-> rdata_o == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctrl_rb; $past(rd_ctl) |-> rdata_o == {2'h0, ctrl_reg[5:0]}; endproperty
	a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
	property p_os_rb; $past(rd_os) |-> rdata_o == {4'h0, outsel_reg[3:0]}; endproperty
	a_os_rb: assert property (p_os_rb) else $error("output select readback wrong");
	property p_mask_rb; $past(rd_msk) |-> rdata_o == {3'h0, mask_reg[4:0]}; endproperty
	a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
	property p_cnt_wr;
		is_wr && addr == `EBT_ADDR_COUNT ##1 is_rd && addr == `EBT_ADDR_COUNT
			|=> rdata_o == $past(bus_i.wdata, 2) || rdata_o == 8'h00;
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");
	property p_cmp_wr;
		wr_cmp ##1 is_rd && addr == $past(addr) |=> rdata_o == $past(bus_i.wdata, 2);
	endproperty
	a_cmp_wr: assert property (p_cmp_wr) else $error("compare write lost");
	property p_irq_mask; mask_reg[4:0] == 5'h00 && $past(mask_reg[4:0]) == 5'h00 |-> !irq_o;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
	property p_out_stop; stop_reg == 2'h3 |=> $stable(timer_out_o); endproperty
	a_out_stop: assert property (p_out_stop) else $error("output moved while stopped");
endmodule : ebt_timer_checker

// *** testbench/ebt_timer_tb.sv ***
`timescale 1ns/1ps
`include "ebt_consts.svh"

module ebt_timer_tb
	import ebt_pkg::*;
;
	logic         clk_i;
	logic         rst_n_i;
	ebt_bus_req_t bus_i;
	ebt_pins_t    pins_i;
	logic   [7:0] rdata_o;
	logic         timer_out_o;
	logic         irq_o;
	logic   [7:0] q;
	int           miscompares = 0;
	int           check_count = 0;

	ebt_timer ebt_timer_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.pins_i(pins_i), .timer_out_o(timer_out_o), .irq_o(irq_o));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_i.addr  <= a;
		bus_i.wdata <= d;
		bus_i.wr    <= 1'b1;
		@(posedge clk_i);
		bus_i.wr <= 1'b0;
	endtask : wr

	// read issued in the cycle right after the write, so no count slips between
	task automatic wr_rd(input logic [3:0] wa, input logic [7:0] wd, input logic [3:0] ra,
		output logic [7:0] d);
		if (wa != ra || wd != 8'h00 || ra != 4'h0) wr(wa, wd);
		bus_i.addr <= ra;
		bus_i.rd   <= 1'b1;
		@(posedge clk_i);
		bus_i.rd <= 1'b0;
		#1 d = rdata_o;
	endtask : wr_rd

	task automatic wait_out(input logic v, output int n);
		n = 0;
		#1;
		while (timer_out_o !== v && n < 2000) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask : wait_out

	////////////////////////////////////////
	task automatic t_reset;
		wr(4'h9, 8'h5a);
		for (int i = 0; i < 10; i++) begin
			wr_rd(4'h0, 8'h00, i[3:0], q);
			chk(q, (i >= 3 && i <= 5) ? `EBT_RST_CMP : 8'h00);
		end
		$display("test reset values done");
	endtask : t_reset

	task automatic t_pulse;
		int n;
		int hi;
		int lo;
		wr(`EBT_ADDR_CMPA, 8'h09);
		wr(`EBT_ADDR_CMPB, 8'h03);
		wr(`EBT_ADDR_OUTSEL, 8'h06);
		wr(`EBT_ADDR_CTRL, {3'h0, `EBT_CCLR_MATCHA, `EBT_CKS_DIV8});
		wait_out(1'b1, n);
		wait_out(1'b0, hi);
		wait_out(1'b1, lo);
		chk(hi[7:0], 8'h20);
		chk(8'(hi + lo), 8'h50);
		wr_rd(4'h0, 8'h00, `EBT_ADDR_FLAGS, q);
		chk(q & 8'h03, 8'h03);
		wr(`EBT_ADDR_CTRL, 8'h00);
		$display("test pulse train done");
	endtask : t_pulse

	task automatic t_prio;
		logic       prev;
		logic       exp;
		logic [1:0] act;
		wr(`EBT_ADDR_CMPA, 8'h05);
		wr(`EBT_ADDR_CMPB, 8'h05);
		for (int i = 0; i < 16; i++) begin
			wr(`EBT_ADDR_COUNT, 8'h00);
			wr(`EBT_ADDR_OUTSEL, {4'h0, i[3:0]});
			#1 prev = timer_out_o;
			act = (i[3:2] > i[1:0]) ? i[3:2] : i[1:0];
			exp = act == `EBT_ACT_TOGGLE ? ~prev : act == `EBT_ACT_HIGH ? 1'b1 :
				act == `EBT_ACT_LOW ? 1'b0 : prev;
			wr(`EBT_ADDR_CTRL, {3'h0, `EBT_CCLR_MATCHA, `EBT_CKS_DIV8});
			repeat (60) @(posedge clk_i);
			wr(`EBT_ADDR_CTRL, 8'h00);
			#1 chk({7'h00, timer_out_o}, {7'h00, exp});
		end
		$display("test match priority done");
	endtask : t_prio

	task automatic t_ovf;
		wr(`EBT_ADDR_MASK, 8'h04);
		wr(`EBT_ADDR_COUNT, 8'hfe);
		wr_rd(4'h0, 8'h00, `EBT_ADDR_FLAGS, q);
		wr(`EBT_ADDR_CTRL, {5'h00, `EBT_CKS_DIV8});
		repeat (24) @(posedge clk_i);
		#1 chk({7'h00, irq_o}, 8'h01);
		wr(`EBT_ADDR_CTRL, 8'h00);
		wr_rd(4'h0, 8'h00, `EBT_ADDR_FLAGS, q);
		chk(q & 8'h04, 8'h04);
		repeat (2) @(posedge clk_i);
		#1 chk({7'h00, irq_o}, 8'h00);
		wr(`EBT_ADDR_MASK, 8'h00);
		$display("test overflow done");
	endtask : t_ovf

	// stride of five clocks walks every phase of the divide-by-eight count pulse
	task automatic sweep(input logic [3:0] wa, input logic [7:0] wd, input logic [7:0] hit,
		input logic [7:0] other, input logic [7:0] hits_exp);
		logic [7:0] hits;
		hits = 8'h00;
		wr(`EBT_ADDR_COUNT, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr_rd(wa, wd, `EBT_ADDR_COUNT, q);
			if (q === hit) hits++;
			else chk(q, other);
			wr(`EBT_ADDR_COUNT, 8'h00);
		end
		chk(hits, hits_exp);
	endtask : sweep

	task automatic t_contend;
		wr(`EBT_ADDR_CMPA, 8'h00);
		wr(`EBT_ADDR_CTRL, {5'h00, `EBT_CKS_DIV8});
		sweep(`EBT_ADDR_COUNT, 8'h40, 8'h40, 8'h40, 8'h08);
		wr(`EBT_ADDR_CTRL, {3'h0, `EBT_CCLR_MATCHA, `EBT_CKS_DIV8});
		sweep(`EBT_ADDR_COUNT, 8'h33, 8'h00, 8'h33, 8'h01);
		sweep(`EBT_ADDR_CMPA, 8'h00, 8'h01, 8'h00, 8'h01);
		wr(`EBT_ADDR_CTRL, 8'h00);
		wr_rd(`EBT_ADDR_CMPB, 8'h77, `EBT_ADDR_CMPB, q);
		chk(q, 8'h77);
		$display("test contention done");
	endtask : t_contend

	// pins pass the synchroniser, so give them eight clocks to settle
	task automatic t_pins;
		pins_i.ext_clk <= 1'b1;
		repeat (8) @(posedge clk_i);
		wr(`EBT_ADDR_COUNT, 8'h10);
		wr(`EBT_ADDR_CTRL, {5'h00, `EBT_CKS_EXT_FALL});
		wr(`EBT_ADDR_CTRL, 8'h00);
		wr_rd(4'h0, 8'h00, `EBT_ADDR_COUNT, q);
		chk(q, 8'h11);
		wr(`EBT_ADDR_CTRL, 8'h20);
		wr(`EBT_ADDR_COUNT, 8'h2a);
		wr_rd(4'h0, 8'h20, `EBT_ADDR_FLAGS, q);
		pins_i.capture <= 1'b1;
		repeat (8) @(posedge clk_i);
		wr_rd(4'h0, 8'h20, `EBT_ADDR_CMPC, q);
		chk(q, 8'h2a);
		wr_rd(4'h0, 8'h20, `EBT_ADDR_FLAGS, q);
		chk(q & 8'h10, 8'h10);
		pins_i.capture <= 1'b0;
		pins_i.ext_clk <= 1'b0;
		wr(`EBT_ADDR_CTRL, 8'h00);
		$display("test pins done");
	endtask : t_pins

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		$display("watchdog expired at %0t", $time);
		finish_test();
	end

	initial begin
		rst_n_i = 1'b0;
		bus_i   = '0;
		pins_i  = '0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_pulse();
		t_prio();
		t_ovf();
		t_contend();
		t_pins();
		finish_test();
	end
endmodule : ebt_timer_tb

bind ebt_timer ebt_timer_checker ebt_timer_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.bus_i(bus_i), .rdata_o(rdata_o), .pins_i(pins_i), .timer_out_o(timer_out_o),
	.irq_o(irq_o));
